// ### shared/tpio_map.svh
// Register map, field layout, reset values and widths of the three-port
// parallel I/O block. Assumes word-indexed byte registers on a 32-bit bus.
// Functional notes
// - Port A: seven pins, latch, direction each.
// - Reset leaves all port data latches unchanged.
// - Direction 1 drives pin, 0 makes input.
// - Reset clears port A direction bits.
// - Reset clears port B direction bits.
// - Port A read: latch if output, else pin.
// - Port B read: latch if output, else pin.
// - Data writes always update latch, any direction.
// - Port A pullup only while pin is input.
// - Port A pullup bit 1 connects, 0 disconnects.
// - Port B: eight pins, no pullups.
// - Port C: three pins, pullups, bit 2 input-only.
// - Interrupt enabled: port C bit 2 reads 0.
// - Interrupt disabled: bit 2 real, branch sees 1.
// - Keypad enables turn port A pins to interrupts.
// - Reset clears port C direction bits.
// - Port C read: latch if output, else pin.
`ifndef TPIO_MAP_SVH
`define TPIO_MAP_SVH

// Printed offsets are register indices; byte address is four times index.
`define TPIO_IDX_A_DATA  8'h00
`define TPIO_IDX_B_DATA  8'h01
`define TPIO_IDX_C_DATA  8'h02
`define TPIO_IDX_A_DIR   8'h04
`define TPIO_IDX_B_DIR   8'h05
`define TPIO_IDX_C_DIR   8'h06
`define TPIO_IDX_A_PUE   8'h0D
`define TPIO_IDX_C_PUE   8'h0E
`define TPIO_IDX_KBI_EN  8'h10

`define TPIO_A_WIDTH     7
`define TPIO_B_WIDTH     8
`define TPIO_C_WIDTH     3
`define TPIO_C_DIR_WIDTH 2
`define TPIO_C_IN_ONLY   2
`define TPIO_OSC2EN_BIT  7

`define TPIO_DIR_RESET   8'h00
`define TPIO_PUE_RESET   8'h00

`define TPIO_RESP_OKAY   2'b00
`define TPIO_RESP_SLVERR 2'b10

`endif

// ### shared/tpio_pkg.sv
// Types shared by the three-port parallel I/O block.
// Assumes the constants of tpio_map.svh are included by the user.
package tpio_pkg;
	typedef logic [1:0] tpio_resp_t;
	typedef enum logic [1:0] {
		TPIO_W_IDLE = 2'b00,
		TPIO_W_HAVE = 2'b01,
		TPIO_W_RESP = 2'b11
	} tpio_wstate_t;
endpackage : tpio_pkg

// ### verilog/tpio_top.sv
// Three-port parallel I/O block with an AXI4-Lite register slave.
// Assumes pins are synchronous to aclk and pads resolve enables outside.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "tpio_map.svh"

module tpio_top #(
	parameter int A_W = `TPIO_A_WIDTH,
	parameter int B_W = `TPIO_B_WIDTH,
	parameter int C_W = `TPIO_C_WIDTH
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [9:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [9:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [A_W-1:0]    port_a_in,
	output logic      [A_W-1:0]    port_a_out,
	output logic      [A_W-1:0]    port_a_oe,
	output logic      [A_W-1:0]    port_a_pullup,
	input  wire logic [B_W-1:0]    port_b_in,
	output logic      [B_W-1:0]    port_b_out,
	output logic      [B_W-1:0]    port_b_oe,
	input  wire logic [C_W-1:0]    port_c_in,
	output logic      [C_W-1:0]    port_c_out,
	output logic      [C_W-1:0]    port_c_oe,
	output logic      [C_W-1:0]    port_c_pullup,
	output logic                   osc2_clock_out_en,
	input  wire logic              irq_function_en,
	output logic                   irq_branch_level,
	output logic      [A_W-1:0]    keypad_pin_interrupt_enables,
	output logic      [A_W-1:0]    keypad_inputs,
	input  wire logic [A_W-1:0]    alt_a_claim,
	input  wire logic [A_W-1:0]    alt_a_out,
	input  wire logic [A_W-1:0]    alt_a_oe,
	input  wire logic [B_W-1:0]    alt_b_claim,
	input  wire logic [B_W-1:0]    alt_b_out,
	input  wire logic [B_W-1:0]    alt_b_oe,
	input  wire logic [C_W-1:0]    alt_c_claim,
	input  wire logic [C_W-1:0]    alt_c_out,
	input  wire logic [C_W-1:0]    alt_c_oe
);

	initial begin
		if (A_W != `TPIO_A_WIDTH || B_W != `TPIO_B_WIDTH ||
			C_W != `TPIO_C_WIDTH)
			$error("tpio_top: port widths are fixed by the map");
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [A_W-1:0] port_a_data_q;
	logic [B_W-1:0] port_b_data_q;
	logic [C_W-1:0] port_c_data_q;
	logic [A_W-1:0] port_a_direction_q;
	logic [B_W-1:0] port_b_direction_q;
	logic [`TPIO_C_DIR_WIDTH-1:0] port_c_direction_q;
	logic [A_W-1:0] port_a_pullup_enable_q;
	logic [C_W-1:0] port_c_pullup_enable_q;
	logic           osc2_en_q;
	logic [A_W-1:0] kbi_en_q;

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data may arrive in either order.

	tpio_pkg::tpio_wstate_t wstate_q;
	logic       aw_have_q;
	logic       w_have_q;
	logic [7:0] aw_idx_q;
	logic [7:0] w_byte_q;
	logic       w_strb_q;
	logic       w_fire;
	logic       w_mapped;

	function automatic logic idx_mapped(input logic [7:0] idx);
		case (idx)
			`TPIO_IDX_A_DATA, `TPIO_IDX_B_DATA, `TPIO_IDX_C_DATA,
			`TPIO_IDX_A_DIR, `TPIO_IDX_B_DIR, `TPIO_IDX_C_DIR,
			`TPIO_IDX_A_PUE, `TPIO_IDX_C_PUE, `TPIO_IDX_KBI_EN:
				idx_mapped = 1'b1;
			default:
				idx_mapped = 1'b0;
		endcase
	endfunction : idx_mapped

	assign s_axi_awready = (wstate_q != tpio_pkg::TPIO_W_RESP) && !aw_have_q;
	assign s_axi_wready  = (wstate_q != tpio_pkg::TPIO_W_RESP) && !w_have_q;
	assign w_fire   = aw_have_q && w_have_q &&
		(wstate_q != tpio_pkg::TPIO_W_RESP);
	assign w_mapped = idx_mapped(aw_idx_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_idx_q  <= 8'h00;
			w_byte_q  <= 8'h00;
			w_strb_q  <= 1'b0;
		end else if (w_fire) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[9:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_strb_q <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_q     <= tpio_pkg::TPIO_W_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TPIO_RESP_OKAY;
		end else begin
			case (wstate_q)
				tpio_pkg::TPIO_W_IDLE, tpio_pkg::TPIO_W_HAVE: begin
					if (w_fire) begin
						wstate_q     <= tpio_pkg::TPIO_W_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= w_mapped ? `TPIO_RESP_OKAY :
							`TPIO_RESP_SLVERR;
					end else if (aw_have_q || w_have_q) begin
						wstate_q <= tpio_pkg::TPIO_W_HAVE;
					end
				end
				tpio_pkg::TPIO_W_RESP: begin
					if (s_axi_bready) begin
						wstate_q     <= tpio_pkg::TPIO_W_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wstate_q     <= tpio_pkg::TPIO_W_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	logic wr_en;
	assign wr_en = w_fire && w_strb_q;

	////////////////////////////////////////////////////////////////////////
	// Data latches carry no reset, so a reset keeps the last written level.

	always_ff @(posedge aclk) begin
		// Latches load in any direction; inputs read the pin, not this.
		if (wr_en && aw_idx_q == `TPIO_IDX_A_DATA)
			port_a_data_q <= w_byte_q[A_W-1:0];
		if (wr_en && aw_idx_q == `TPIO_IDX_B_DATA)
			port_b_data_q <= w_byte_q[B_W-1:0];
		if (wr_en && aw_idx_q == `TPIO_IDX_C_DATA)
			port_c_data_q <= w_byte_q[C_W-1:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_direction_q <= A_W'(`TPIO_DIR_RESET);
			port_b_direction_q <= B_W'(`TPIO_DIR_RESET);
			port_c_direction_q <= `TPIO_C_DIR_WIDTH'(`TPIO_DIR_RESET);
		end else if (wr_en) begin
			if (aw_idx_q == `TPIO_IDX_A_DIR)
				port_a_direction_q <= w_byte_q[A_W-1:0];
			if (aw_idx_q == `TPIO_IDX_B_DIR)
				port_b_direction_q <= w_byte_q[B_W-1:0];
			if (aw_idx_q == `TPIO_IDX_C_DIR)
				port_c_direction_q <= w_byte_q[`TPIO_C_DIR_WIDTH-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_pullup_enable_q <= A_W'(`TPIO_PUE_RESET);
			port_c_pullup_enable_q <= C_W'(`TPIO_PUE_RESET);
			osc2_en_q              <= 1'b0;
			kbi_en_q               <= A_W'(`TPIO_PUE_RESET);
		end else if (wr_en) begin
			if (aw_idx_q == `TPIO_IDX_A_PUE)
				port_a_pullup_enable_q <= w_byte_q[A_W-1:0];
			if (aw_idx_q == `TPIO_IDX_C_PUE) begin
				port_c_pullup_enable_q <= w_byte_q[C_W-1:0];
				osc2_en_q <= w_byte_q[`TPIO_OSC2EN_BIT];
			end
			if (aw_idx_q == `TPIO_IDX_KBI_EN)
				kbi_en_q <= w_byte_q[A_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers. A claiming peripheral outranks the port logic.

	logic [C_W-1:0] c_dir;
	assign c_dir = {1'b0, port_c_direction_q};

	always_comb begin
		for (int i = 0; i < A_W; i++) begin
			port_a_out[i] = alt_a_claim[i] ? alt_a_out[i] : port_a_data_q[i];
			port_a_oe[i]  = alt_a_claim[i] ? alt_a_oe[i] :
				port_a_direction_q[i];
		end
		for (int i = 0; i < B_W; i++) begin
			port_b_out[i] = alt_b_claim[i] ? alt_b_out[i] : port_b_data_q[i];
			port_b_oe[i]  = alt_b_claim[i] ? alt_b_oe[i] :
				port_b_direction_q[i];
		end
		for (int i = 0; i < C_W; i++) begin
			port_c_out[i] = alt_c_claim[i] ? alt_c_out[i] : port_c_data_q[i];
			port_c_oe[i]  = alt_c_claim[i] ? alt_c_oe[i] : c_dir[i];
		end
	end

	// Pullups drop the moment a pin turns output, even if the bit stays set.
	assign port_a_pullup = port_a_pullup_enable_q & ~port_a_oe;
	assign port_c_pullup = port_c_pullup_enable_q & ~port_c_oe;
	assign osc2_clock_out_en = osc2_en_q;
	assign keypad_pin_interrupt_enables = kbi_en_q;
	assign keypad_inputs = port_a_in & kbi_en_q;
	// With the interrupt function off, branch tests see a fixed high.
	assign irq_branch_level = irq_function_en ?
		port_c_in[`TPIO_C_IN_ONLY] : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data.

	logic [7:0] rd_byte;
	logic       rd_ok;
	logic [C_W-1:0] c_view;

	always_comb begin
		c_view = (c_dir & port_c_data_q) | (~c_dir & port_c_in);
		if (irq_function_en)
			c_view[`TPIO_C_IN_ONLY] = 1'b0;
		rd_ok   = idx_mapped(s_axi_araddr[9:2]);
		rd_byte = 8'h00;
		case (s_axi_araddr[9:2])
			`TPIO_IDX_A_DATA: rd_byte[A_W-1:0] =
				(port_a_direction_q & port_a_data_q) |
				(~port_a_direction_q & port_a_in);
			`TPIO_IDX_B_DATA: rd_byte[B_W-1:0] =
				(port_b_direction_q & port_b_data_q) |
				(~port_b_direction_q & port_b_in);
			`TPIO_IDX_C_DATA: rd_byte[C_W-1:0] = c_view;
			`TPIO_IDX_A_DIR:  rd_byte[A_W-1:0] = port_a_direction_q;
			`TPIO_IDX_B_DIR:  rd_byte[B_W-1:0] = port_b_direction_q;
			`TPIO_IDX_C_DIR:
				rd_byte[`TPIO_C_DIR_WIDTH-1:0] = port_c_direction_q;
			`TPIO_IDX_A_PUE:  rd_byte[A_W-1:0] = port_a_pullup_enable_q;
			`TPIO_IDX_C_PUE: begin
				rd_byte[C_W-1:0] = port_c_pullup_enable_q;
				rd_byte[`TPIO_OSC2EN_BIT] = osc2_en_q;
			end
			`TPIO_IDX_KBI_EN: rd_byte[A_W-1:0] = kbi_en_q;
			default:          rd_byte = 8'h00;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `TPIO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_ok ? `TPIO_RESP_OKAY : `TPIO_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : tpio_top

// ### tb/tpio_pins.sv
// Far side of one port: outside drivers, pullups and floating lines.
// The block drives oe, out and pullup; the bench drives ext_en, ext_val.
`timescale 1ns/1ns
module tpio_pins #(parameter int W = 8) (
	input wire logic         aclk,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] pu_en,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic     [W-1:0] pin
);
	logic [W-1:0] last_q = '0;
	// An undriven line without pullup toggles each cycle, so a stale level never reads back.
	assign pin = (oe & out) | (~oe & ext_en & ext_val)
		| (~oe & ~ext_en & (pu_en | ~last_q));
	always_ff @(posedge aclk) last_q <= pin;
endmodule : tpio_pins

// ### tb/tpio_properties.sv
// Checker for the pin side and read channel of the three-port block.
// Bound to tpio_top; sees only its ports.
`timescale 1ns/1ns
module tpio_properties #(parameter int A_W = 7, parameter int C_W = 3) (
	input wire logic           aclk,
	input wire logic           aresetn,
	input wire logic           s_axi_arvalid,
	input wire logic           s_axi_arready,
	input wire logic           s_axi_rvalid,
	input wire logic           s_axi_rready,
	input wire logic [A_W-1:0] port_a_oe,
	input wire logic [A_W-1:0] port_a_pullup,
	input wire logic [A_W-1:0] alt_a_claim,
	input wire logic [A_W-1:0] alt_a_oe,
	input wire logic [C_W-1:0] port_c_in,
	input wire logic [C_W-1:0] port_c_oe,
	input wire logic [C_W-1:0] alt_c_claim,
	input wire logic           irq_function_en,
	input wire logic           irq_branch_level
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
	a_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (r_wait |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_pullup_gate: assert property ((port_a_pullup & port_a_oe) == '0)
		else $error("pullup on a driven pin");
	a_a_reset_in: assert property ($rose(aresetn) && alt_a_claim == '0
		|-> port_a_oe == '0) else $error("port a drives after reset");
	a_c_reset_in: assert property ($rose(aresetn) && alt_c_claim == '0
		|-> port_c_oe == '0) else $error("port c drives after reset");
	a_claim_wins: assert property (((port_a_oe ^ alt_a_oe) & alt_a_claim) == '0)
		else $error("claimed pin not handed over");
	a_irq_branch_on: assert property (irq_function_en
		|-> irq_branch_level == port_c_in[2]) else $error("branch level wrong");
	a_irq_branch_off: assert property (!irq_function_en |-> irq_branch_level)
		else $error("branch level not high");
	a_c2_input_only: assert property (!alt_c_claim[2] |-> !port_c_oe[2])
		else $error("input only pin driven");
endmodule : tpio_properties
////////////////////////
bind tpio_top tpio_properties #(.A_W(A_W), .C_W(C_W)) tpio_properties_i (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .port_a_oe, .port_a_pullup, .alt_a_claim, .alt_a_oe,
	.port_c_in, .port_c_oe, .alt_c_claim, .irq_function_en,
	.irq_branch_level);

// ### tb/tpio_top_tb.sv
// Bench: register bus task, pin model on port A, one task per scenario.
// Assumes tpio_map.svh on the include path.
`timescale 1ns/1ns
`include "tpio_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s expected %h seen %h", nm, e, g); end end
////////////////////////
module tpio_top_tb;
	logic aclk = '0, aresetn = '0, irq_en = '0, awv = '0, wv = '0, bry = '0;
	logic arv = '0, rry = '0, awr, wr, bv, arr, rv;
	logic [9:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rdat, rd;
	logic [1:0] bresp, rresp, rsp;
	logic [6:0] a_in, a_out, a_oe, a_pu, kp, a_xe = '0, a_xv = '0;
	logic [6:0] ac = '0, ae = '0;
	logic [7:0] b_in = '0, bc = '0;
	logic [2:0] c_in = '0, c_oe, cc = '0;
	int mismatches = 0, n_tests = 0;
	always #5 aclk = ~aclk;
	tpio_top tpio_top_i (.aclk, .aresetn, .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .port_a_in(a_in), .port_a_out(a_out),
		.port_a_oe(a_oe), .port_a_pullup(a_pu), .port_b_in(b_in),
		.port_b_out(), .port_b_oe(), .port_c_in(c_in), .port_c_out(),
		.port_c_oe(c_oe), .port_c_pullup(), .osc2_clock_out_en(),
		.irq_function_en(irq_en), .irq_branch_level(),
		.keypad_pin_interrupt_enables(), .keypad_inputs(kp),
		.alt_a_claim(ac), .alt_a_out(ae), .alt_a_oe(ae), .alt_b_claim(bc),
		.alt_b_out(bc), .alt_b_oe(bc), .alt_c_claim(cc), .alt_c_out(cc),
		.alt_c_oe(cc));
	tpio_pins #(.W(7)) tpio_pins_i (.aclk, .oe(a_oe), .out(a_out),
		.pu_en(a_pu), .ext_en(a_xe), .ext_val(a_xv), .pin(a_in));
	task automatic acc(input logic w, input logic [7:0] ix,
		input logic [7:0] d);
		logic done;
		done = 1'b0;
		rd = 'x;
		awa <= {ix, 2'h0};
		ara <= {ix, 2'h0};
		wd <= {24'h0, d};
		awv <= w;
		wv <= w;
		bry <= w;
		arv <= !w;
		rry <= !w;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
			if (arr) arv <= 1'h0;
			if ((bry && bv) || (rry && rv)) begin
				rd = rdat;
				rsp = w ? bresp : rresp;
				bry <= 1'h0;
				rry <= 1'h0;
				done = 1'b1;
				break;
			end
		end
		// A bus that never answers counts against the run.
		if (!done) mismatches++;
		// Let the release settle before the next call drives the bus again.
		@(posedge aclk);
	endtask : acc
	task automatic rdc(input string nm, input logic [7:0] ix,
		input logic [31:0] e);
		acc(1'h0, ix, 8'h00);
		`CHK(nm, e, rd)
	endtask : rdc
	task t_a;
		a_xe <= 7'h7F;
		a_xv <= 7'h2A;
		acc(1'h1, `TPIO_IDX_A_DATA, 8'h55);
		rdc("a_in", `TPIO_IDX_A_DATA, 32'h2A);
		a_xe <= 7'h70;
		acc(1'h1, `TPIO_IDX_A_DIR, 8'h0F);
		rdc("a_mix", `TPIO_IDX_A_DATA, 32'h25);
		acc(1'h1, `TPIO_IDX_A_PUE, 8'h7F);
		a_xe <= 7'h00;
		`CHK("a_pu", 7'h70, a_pu)
		rdc("a_pull", `TPIO_IDX_A_DATA, 32'h75);
		acc(1'h1, `TPIO_IDX_KBI_EN, 8'h7F);
		`CHK("keypad", 7'h75, kp)
	endtask : t_a
	task t_bc;
		b_in <= 8'hA5;
		c_in <= 3'h4;
		acc(1'h1, `TPIO_IDX_B_DATA, 8'h3C);
		acc(1'h1, `TPIO_IDX_B_DIR, 8'h0F);
		rdc("b_mix", `TPIO_IDX_B_DATA, 32'hAC);
		acc(1'h1, `TPIO_IDX_C_DATA, 8'h02);
		acc(1'h1, `TPIO_IDX_C_DIR, 8'h03);
		`CHK("c_oe", 3'h3, c_oe)
		irq_en <= 1'h1;
		rdc("c_irq_on", `TPIO_IDX_C_DATA, 32'h2);
		irq_en <= 1'h0;
		rdc("c_irq_off", `TPIO_IDX_C_DATA, 32'h6);
	endtask : t_bc
	task t_rst;
		acc(1'h1, `TPIO_IDX_A_DATA, 8'h32);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rdc("a_dir", `TPIO_IDX_A_DIR, 32'h0);
		rdc("b_dir", `TPIO_IDX_B_DIR, 32'h0);
		rdc("c_dir", `TPIO_IDX_C_DIR, 32'h0);
		acc(1'h1, `TPIO_IDX_A_DIR, 8'h7F);
		`CHK("a_kept", 7'h32, a_out)
		ac <= 7'h01;
		ae <= 7'h01;
		@(posedge aclk);
		`CHK("a_claim", 7'h33, a_out)
		acc(1'h1, 8'h20, 8'hFF);
		`CHK("bad_addr", `TPIO_RESP_SLVERR, rsp)
	endtask : t_rst
	task complete_run;
		if (mismatches == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_a();
		t_bc();
		t_rst();
		complete_run();
	end
	// About twenty accesses of a few cycles each; ample margin beyond that.
	initial begin
		repeat (3000) @(posedge aclk);
		mismatches++;
		complete_run();
	end
endmodule : tpio_top_tb
